// ### dv/sag_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module sag_bus_model
  import sag_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Address result from the generator.
  input wire sag_resp_t resp,
  // Captured bus activity.
  output logic [23:0] last_addr,
  output logic [15:0] n_access
);
  // ****************************************
  // Memory bus side.
  // ****************************************
  // Only executed accesses reach the bus; a trapped access never does.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      last_addr <= 24'h000000;
      n_access <= 16'h0000;
    end else if (resp.valid && !resp.trap) begin
      last_addr <= resp.addr;
      n_access <= n_access + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### dv/test_sag_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_sag_core
  import sag_pkg::*;
;
  logic clock;
  logic rstn;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  sag_req_t req;
  sag_resp_t resp;
  logic [23:0] last_addr;
  logic [15:0] n_access;
  int n_errors;
  int n_compared;
  int n_valid;

  sag_core DUT (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .resp(resp));
  sag_bus_model mem (.clock(clock), .rstn(rstn), .resp(resp), .last_addr(last_addr),
    .n_access(n_access));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ****************************************
  // Shared tasks.
  // ****************************************
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task rdc(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Flags are byte_op, local_bank, ext_space, page_ovr, seg_ovr.
  task issue(input sag_mode_t m, input logic [15:0] op, input logic [4:0] fl,
    input logic [23:0] ea, input logic et);
    sag_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.mode = m;
    q.operand = op;
    {q.byte_op, q.local_bank, q.ext_space, q.page_ovr, q.seg_ovr} = fl;
    q.page_num = 10'h2a5;
    q.seg_num = 8'h3c;
    @(posedge clock);
    req <= q;
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    chk({23'h0, resp.trap}, {23'h0, et});
    chk({23'h0, resp.valid}, {23'h0, ~et});
    chk(resp.addr, ea);
    if (!et) n_valid++;
  endtask

  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    n_errors = 0;
    n_compared = 0;
    n_valid = 0;
    rstn = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req = '0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rdc(3'h0, 16'hfc00);
    for (int i = 0; i < 4; i++) begin
      rdc(3'h1 + 3'(i), 16'(i));
    end
    rdc(3'h5, 16'h0000);
    wr(3'h7, 16'hffff);
    rdc(3'h7, 16'h0000);
    wr(3'h0, 16'h01fe);
    rdc(3'h0, 16'hfdfe);
    wr(3'h0, 16'h0a41);
    rdc(3'h0, 16'hfa40);
    issue(SAG_WGPR, 16'h000f, 5'h00, 24'h00fa5e, 1'b0);
    issue(SAG_WGPR, 16'h0000, 5'h00, 24'h00fa40, 1'b0);
    issue(SAG_BGPR, 16'h000f, 5'h10, 24'h00fa4f, 1'b0);
    chk({23'h0, resp.byte_op}, 24'h000001);
    issue(SAG_WGPR, 16'h0003, 5'h08, 24'h000000, 1'b0);
    chk({19'h0, resp.local_sel, resp.local_index}, 24'h000013);
    issue(SAG_BGPR, 16'h0005, 5'h18, 24'h000000, 1'b0);
    chk({19'h0, resp.local_sel, resp.local_index}, 24'h000015);
    issue(SAG_REG, 16'hff00, 5'h00, 24'h00fe00, 1'b0);
    issue(SAG_REG, 16'h00ef, 5'h00, 24'h00ffde, 1'b0);
    issue(SAG_REG, 16'h00ef, 5'h04, 24'h00f1de, 1'b0);
    issue(SAG_REG, 16'h0010, 5'h14, 24'h00f020, 1'b0);
    chk({23'h0, resp.byte_op}, 24'h000001);
    issue(SAG_REG, 16'h00f7, 5'h00, 24'h00fa4e, 1'b0);
    issue(SAG_REG, 16'h00ff, 5'h10, 24'h00fa4f, 1'b0);
    issue(SAG_BITOFF, 16'h5a00, 5'h00, 24'h00fd00, 1'b0);
    issue(SAG_BITOFF, 16'h007f, 5'h00, 24'h00fdfe, 1'b0);
    issue(SAG_BITOFF, 16'h0080, 5'h00, 24'h00ff00, 1'b0);
    issue(SAG_BITOFF, 16'h00ef, 5'h04, 24'h00f1de, 1'b0);
    issue(SAG_BITOFF, 16'h00f3, 5'h04, 24'h00fa46, 1'b0);
    issue(SAG_BITADDR, 16'h0a7f, 5'h00, 24'h00fdfe, 1'b0);
    chk({19'h0, resp.bit_valid, resp.bit_pos}, 24'h00001a);
    issue(SAG_LONG, 16'h4002, 5'h00, 24'h004002, 1'b0);
    wr(3'h3, 16'hffff);
    rdc(3'h3, 16'h03ff);
    issue(SAG_LONG, 16'h8004, 5'h00, 24'hffc004, 1'b0);
    issue(SAG_LONG, 16'hc010, 5'h02, 24'ha94010, 1'b0);
    issue(SAG_LONG, 16'hc010, 5'h03, 24'h3cc010, 1'b0);
    issue(SAG_LONG, 16'h4003, 5'h00, 24'h000000, 1'b1);
    issue(SAG_LONG, 16'h4003, 5'h10, 24'h004003, 1'b0);
    rdc(3'h5, 16'h0001);
    chk({8'h00, n_access}, 24'(n_valid));
    chk(last_addr, 24'h004003);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/sag_core.sv
`timescale 1ns/1ps
`default_nettype none
module sag_core
  import sag_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Address request and result.
  input wire sag_req_t req,
  output sag_resp_t resp
);

  // ****************************************
  // Software-visible state.
  // ****************************************
  logic [15:0] context_base;
  logic [3:0][PAGE_NUM_W-1:0] page_pointer_slot;
  logic [15:0] trap_count;

  // ****************************************
  // Register port decode.
  // ****************************************
  wire logic wr_ctx = reg_wr && (reg_addr == OFF_CTX);
  wire logic [3:0] wr_pp;
  wire logic ctx_low = (reg_wdata[11:9] == 3'h0);
  wire logic [1:0] ctx_hi = ctx_low ? CTX_FORCE : reg_wdata[11:10];
  wire logic [15:0] next_context_base = {CTX_TOP, ctx_hi, reg_wdata[9:1], 1'b0};
  wire logic [15:0] rd_mux;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pp
      assign wr_pp[gi] = reg_wr && (reg_addr == OFF_PP0 + 3'(gi));
      always_ff @(posedge clock) begin
        if (!rstn) begin
          page_pointer_slot[gi] <= PAGE_NUM_W'(gi);
        end else if (wr_pp[gi]) begin
          page_pointer_slot[gi] <= reg_wdata[PAGE_NUM_W-1:0];
        end
      end
    end
  endgenerate

  assign rd_mux =
    (reg_addr == OFF_CTX) ? context_base :
    (reg_addr == OFF_PP0) ? {6'h00, page_pointer_slot[0]} :
    (reg_addr == OFF_PP1) ? {6'h00, page_pointer_slot[1]} :
    (reg_addr == OFF_PP2) ? {6'h00, page_pointer_slot[2]} :
    (reg_addr == OFF_PP3) ? {6'h00, page_pointer_slot[3]} :
    (reg_addr == OFF_TRAPS) ? trap_count : 16'h0000;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      context_base <= CTX_RESET;
    end else if (wr_ctx) begin
      context_base <= next_context_base;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ****************************************
  // Operand fields.
  // ****************************************
  wire logic [3:0] gidx = req.operand[3:0];
  wire logic [7:0] short8 = req.operand[7:0];
  wire logic [3:0] bitpos = req.operand[11:8];
  wire logic [23:0] cb24 = {8'h00, context_base};
  wire logic is_reg = (req.mode == SAG_REG);
  wire logic is_bit = (req.mode == SAG_BITOFF) || (req.mode == SAG_BITADDR);
  wire logic is_long = (req.mode == SAG_LONG);

  // ****************************************
  // General purpose slot addresses.
  // ****************************************
  wire logic [23:0] wgpr_addr = cb24 + {19'h0, gidx, 1'b0};
  wire logic [23:0] bgpr_addr = cb24 + {20'h0, gidx};

  // ****************************************
  // Special function space operand.
  // ****************************************
  wire logic reg_gpr = (short8 >= GPR_FIRST);
  wire logic [23:0] reg_base = req.ext_space ? EXT_SPECIAL_BASE : SFR_BASE;
  wire logic [23:0] reg_sfr_addr = reg_base + {15'h0, short8, 1'b0};
  wire logic [23:0] reg_gpr_addr = req.byte_op ? bgpr_addr : wgpr_addr;

  // ****************************************
  // Bit-space word offset.
  // ****************************************
  wire logic bit_ram = (short8 < BIT_SFR_FIRST);
  wire logic bit_gpr = (short8 >= GPR_FIRST);
  wire logic [23:0] bit_ram_addr = RAMBIT_BASE + {15'h0, short8, 1'b0};
  wire logic [23:0] bit_sbase = req.ext_space ? EXT_BIT_BASE : SFRBIT_BASE;
  wire logic [23:0] bit_sfr_addr = bit_sbase + {16'h0, short8[6:0], 1'b0};
  wire logic [23:0] bit_addr =
    bit_ram ? bit_ram_addr : (bit_gpr ? wgpr_addr : bit_sfr_addr);

  // ****************************************
  // Long and indirect address.
  // ****************************************
  wire logic [23:0] long_addr24;

  sag_long_xlate u_long (
    .long_addr(req.operand),
    .page_pointer_slot(page_pointer_slot),
    .page_ovr(req.page_ovr),
    .page_num(req.page_num),
    .seg_ovr(req.seg_ovr),
    .seg_num(req.seg_num),
    .phys_addr(long_addr24)
  );

  wire logic long_trap = is_long && !req.byte_op && req.operand[0];

  // ****************************************
  // Result selection.
  // ****************************************
  wire logic uses_gpr =
    (req.mode == SAG_WGPR) || (req.mode == SAG_BGPR) ||
    (is_reg && reg_gpr) || (is_bit && bit_gpr);
  wire logic go_local = uses_gpr && req.local_bank;
  wire logic [23:0] global_addr =
    (req.mode == SAG_WGPR) ? wgpr_addr :
    (req.mode == SAG_BGPR) ? bgpr_addr :
    is_reg ? (reg_gpr ? reg_gpr_addr : reg_sfr_addr) :
    is_bit ? bit_addr :
    is_long ? long_addr24 : 24'h000000;
  wire logic [23:0] sel_addr = (go_local || long_trap) ? 24'h000000 : global_addr;
  wire logic sel_byte =
    (req.mode == SAG_BGPR) || (is_reg && req.byte_op) || (is_long && req.byte_op);

  sag_resp_t next_resp;

  always_comb begin
    next_resp = '0;
    next_resp.valid = req.valid && !long_trap;
    next_resp.trap = req.valid && long_trap;
    next_resp.local_sel = req.valid && go_local;
    next_resp.local_index = (req.valid && go_local) ? gidx : 4'h0;
    next_resp.addr = req.valid ? sel_addr : 24'h000000;
    next_resp.byte_op = req.valid && sel_byte;
    next_resp.bit_valid = req.valid && (req.mode == SAG_BITADDR);
    next_resp.bit_pos = (req.valid && req.mode == SAG_BITADDR) ? bitpos : 4'h0;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      resp <= '0;
    end else begin
      resp <= next_resp;
    end
  end

  // ****************************************
  // Trap counter.
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      trap_count <= 16'h0000;
    end else if (req.valid && long_trap) begin
      trap_count <= trap_count + 16'h0001;
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (!rstn);

  property p_wgpr;
    (req.valid && req.mode == SAG_WGPR && !req.local_bank)
      |=> resp.valid && resp.addr == $past(cb24) + {19'h0, $past(req.operand[3:0]), 1'b0};
  endproperty
  a_wgpr: assert property (p_wgpr) else $error("word slot address wrong");

  property p_bgpr;
    (req.valid && req.mode == SAG_BGPR && !req.local_bank)
      |=> resp.byte_op && resp.addr == $past(cb24) + {20'h0, $past(req.operand[3:0])};
  endproperty
  a_bgpr: assert property (p_bgpr) else $error("byte slot address wrong");

  property p_local;
    (req.valid && req.local_bank && req.mode == SAG_WGPR)
      |=> resp.local_sel && resp.addr == 24'h000000 &&
          resp.local_index == $past(req.operand[3:0]);
  endproperty
  a_local: assert property (p_local) else $error("local bank index wrong");

  property p_reg_sfr;
    (req.valid && req.mode == SAG_REG && req.operand[7:0] < GPR_FIRST)
      |=> resp.addr == ($past(req.ext_space) ? EXT_SPECIAL_BASE : SFR_BASE) +
          {15'h0, $past(req.operand[7:0]), 1'b0};
  endproperty
  a_reg_sfr: assert property (p_reg_sfr) else $error("special address wrong");

  property p_reg_gpr;
    (req.valid && req.mode == SAG_REG && req.operand[7:0] >= GPR_FIRST &&
     !req.local_bank && !req.byte_op)
      |=> resp.addr == $past(cb24) + {19'h0, $past(req.operand[3:0]), 1'b0};
  endproperty
  a_reg_gpr: assert property (p_reg_gpr) else $error("special GENERAL_PURPOSE_SLOT address wrong");

  property p_bit_ram;
    (req.valid && is_bit && req.operand[7:0] < BIT_SFR_FIRST)
      |=> resp.addr[23:8] == 16'h00fd && resp.addr[0] == 1'b0;
  endproperty
  a_bit_ram: assert property (p_bit_ram) else $error("RAM bit word wrong");

  property p_bit_sfr;
    (req.valid && is_bit && req.operand[7:0] >= BIT_SFR_FIRST &&
     req.operand[7:0] < GPR_FIRST)
      |=> resp.addr == ($past(req.ext_space) ? EXT_BIT_BASE : SFRBIT_BASE) +
          {16'h0, $past(req.operand[6:0]), 1'b0};
  endproperty
  a_bit_sfr: assert property (p_bit_sfr) else $error("special bit word wrong");

  property p_long;
    (req.valid && is_long && !req.seg_ovr && !req.page_ovr && req.byte_op)
      |=> resp.addr ==
          {$past(page_pointer_slot[req.operand[15:14]]), $past(req.operand[13:0])};
  endproperty
  a_long: assert property (p_long) else $error("paged address wrong");

  property p_seg;
    (req.valid && is_long && req.seg_ovr && !long_trap)
      |=> resp.addr == {$past(req.seg_num), $past(req.operand)};
  endproperty
  a_seg: assert property (p_seg) else $error("segment address wrong");

  property p_trap;
    (req.valid && is_long && !req.byte_op && req.operand[0])
      |=> resp.trap && !resp.valid && trap_count == $past(trap_count) + 16'h0001;
  endproperty
  a_trap: assert property (p_trap) else $error("odd word access not trapped");

  property p_ctx;
    (reg_wr && reg_addr == OFF_CTX && reg_wdata[11:9] == 3'h0)
      |=> context_base[11:10] == 2'h3 && context_base[15:12] == 4'hf &&
          context_base[0] == 1'b0;
  endproperty
  a_ctx: assert property (p_ctx) else $error("context base not forced");

  property p_seg0;
    (req.valid && (is_reg || is_bit) && req.operand[7:0] < GPR_FIRST)
      |=> resp.addr[23:16] == 8'h00;
  endproperty
  a_seg0: assert property (p_seg0) else $error("short mode left segment zero");

  property p_bitpos;
    (req.valid && req.mode == SAG_BITADDR)
      |=> resp.bit_valid && resp.bit_pos == $past(req.operand[11:8]);
  endproperty
  a_bitpos: assert property (p_bitpos) else $error("bit position lost");

  property p_idle;
    !req.valid |=> resp == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("result without a request");

  property p_local_byte;
    (req.valid && req.local_bank && req.mode == SAG_BGPR)
      |=> resp.local_sel && resp.byte_op && resp.addr == 24'h000000 &&
          resp.local_index == $past(req.operand[3:0]);
  endproperty
  a_local_byte: assert property (p_local_byte) else $error("local byte index wrong");

  property p_reg_std;
    (req.valid && is_reg && !req.ext_space && req.operand[7:0] < GPR_FIRST)
      |=> resp.addr[23:9] == SFR_BASE[23:9];
  endproperty
  a_reg_std: assert property (p_reg_std) else $error("extended base without prefix");

  property p_reg_low;
    (req.valid && is_reg && req.operand[7:0] < GPR_FIRST)
      |=> resp.addr[0] == 1'b0 && resp.byte_op == $past(req.byte_op);
  endproperty
  a_reg_low: assert property (p_reg_low) else $error("special access width wrong");

  property p_reg_bgpr;
    (req.valid && is_reg && req.operand[7:0] >= GPR_FIRST &&
     !req.local_bank && req.byte_op)
      |=> resp.addr == $past(cb24) + {20'h0, $past(req.operand[3:0])};
  endproperty
  a_reg_bgpr: assert property (p_reg_bgpr) else $error("special byte slot wrong");

  property p_bit_gpr;
    (req.valid && is_bit && req.operand[7:0] >= GPR_FIRST && !req.local_bank)
      |=> resp.addr == $past(cb24) + {19'h0, $past(req.operand[3:0]), 1'b0};
  endproperty
  a_bit_gpr: assert property (p_bit_gpr) else $error("bit word slot wrong");

  property p_bit_std;
    (req.valid && is_bit && !req.ext_space && req.operand[7:0] >= BIT_SFR_FIRST &&
     req.operand[7:0] < GPR_FIRST)
      |=> resp.addr[23:8] == SFRBIT_BASE[23:8];
  endproperty
  a_bit_std: assert property (p_bit_std) else $error("extended bit base without prefix");

  property p_page_ovr;
    (req.valid && is_long && req.page_ovr && !req.seg_ovr && !long_trap)
      |=> resp.addr == {$past(req.page_num), $past(req.operand[13:0])};
  endproperty
  a_page_ovr: assert property (p_page_ovr) else $error("page override ignored");

  property p_word_even;
    (req.valid && is_long && !req.byte_op && !req.operand[0])
      |=> resp.valid && !resp.trap;
  endproperty
  a_word_even: assert property (p_word_even) else $error("even word access trapped");

endmodule
`default_nettype wire

// ### verilog/sag_long_xlate.sv
`timescale 1ns/1ps
`default_nettype none
module sag_long_xlate
  import sag_pkg::*;
(
  // Long address and pointers.
  input wire logic [15:0] long_addr,
  input wire logic [3:0][PAGE_NUM_W-1:0] page_pointer_slot,
  // Override controls.
  input wire logic page_ovr,
  input wire logic [PAGE_NUM_W-1:0] page_num,
  input wire logic seg_ovr,
  input wire logic [SEG_W-1:0] seg_num,
  // Physical address.
  output logic [23:0] phys_addr
);

  // ****************************************
  // Page selection and concatenation.
  // ****************************************
  wire logic [1:0] sel = long_addr[15:SEL_LSB];
  wire logic [PAGE_OFS_W-1:0] page_ofs = long_addr[PAGE_OFS_W-1:0];
  wire logic [PAGE_NUM_W-1:0] pp_page = page_pointer_slot[sel];
  wire logic [PAGE_NUM_W-1:0] use_page = page_ovr ? page_num : pp_page;
  wire logic [23:0] paged_addr = {use_page, page_ofs};
  wire logic [23:0] seg_addr = {seg_num, long_addr};

  assign phys_addr = seg_ovr ? seg_addr : paged_addr;

endmodule
`default_nettype wire

// ### verilog/sag_pkg.sv
`default_nettype none
package sag_pkg;

  // ****************************************
  // Register map of the plain port.
  // ****************************************
  localparam logic [2:0] OFF_CTX = 3'h0;
  localparam logic [2:0] OFF_PP0 = 3'h1;
  localparam logic [2:0] OFF_PP1 = 3'h2;
  localparam logic [2:0] OFF_PP2 = 3'h3;
  localparam logic [2:0] OFF_PP3 = 3'h4;
  localparam logic [2:0] OFF_TRAPS = 3'h5;

  // ****************************************
  // Reset values and fields.
  // ****************************************
  localparam logic [15:0] CTX_RESET = 16'hfc00;
  localparam logic [3:0] CTX_TOP = 4'hf;
  localparam logic [1:0] CTX_FORCE = 2'h3;
  localparam int PAGE_NUM_W = 10;
  localparam int PAGE_OFS_W = 14;
  localparam int SEG_W = 8;
  localparam int SEL_LSB = 14;

  // ****************************************
  // Short-mode bases and range limits.
  // ****************************************
  localparam logic [23:0] SFR_BASE = 24'h00fe00;
  localparam logic [23:0] EXT_SPECIAL_BASE = 24'h00f000;
  localparam logic [23:0] RAMBIT_BASE = 24'h00fd00;
  localparam logic [23:0] SFRBIT_BASE = 24'h00ff00;
  localparam logic [23:0] EXT_BIT_BASE = 24'h00f100;
  localparam logic [7:0] GPR_FIRST = 8'hf0;
  localparam logic [7:0] BIT_SFR_FIRST = 8'h80;

  // ****************************************
  // Operand modes and carriers.
  // ****************************************
  typedef enum logic [2:0] {
    SAG_WGPR = 3'b000,
    SAG_BGPR = 3'b001,
    SAG_REG = 3'b010,
    SAG_BITOFF = 3'b011,
    SAG_BITADDR = 3'b100,
    SAG_LONG = 3'b101
  } sag_mode_t;

  typedef struct packed {
    logic valid;
    sag_mode_t mode;
    logic [15:0] operand;
    logic byte_op;
    logic local_bank;
    logic ext_space;
    logic page_ovr;
    logic [9:0] page_num;
    logic seg_ovr;
    logic [7:0] seg_num;
  } sag_req_t;

  typedef struct packed {
    logic valid;
    logic trap;
    logic local_sel;
    logic [3:0] local_index;
    logic [23:0] addr;
    logic byte_op;
    logic bit_valid;
    logic [3:0] bit_pos;
  } sag_resp_t;

endpackage
`default_nettype wire
